// ### rtl/data_memory_pointer_regs.sv
`timescale 1ns/10ps
module data_memory_pointer_regs
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // decoder controls
  input wire logic page_load,
  input wire logic [pointer_pkg::REG_W-1:0] page_load_val,
  input wire pointer_pkg::word_op_e word_op,
  input wire logic [pointer_pkg::REG_W-1:0] word_load_val,
  input wire logic bank_select_set_instr,
  input wire logic bank_select_clear_instr,
  input wire logic bank_select_test_instr,
  input wire logic bank_select_test_inverted_instr,
  input wire logic port_bit_indirect_instr,
  // results
  output logic [pointer_pkg::REG_W-1:0] page_value,
  output logic [pointer_pkg::REG_W-1:0] word_value,
  output logic memory_bank_select,
  output logic [pointer_pkg::ADDR_W-1:0] mem_addr,
  output logic bank_test_result,
  output logic bank_test_valid,
  output logic [pointer_pkg::PORT_BIT_W-1:0] port_bit_index,
  output logic port_bit_valid
);
  import pointer_pkg::*;

  // ==================================================
  // page and word pointer
  logic [REG_W-1:0] page_reg;
  logic [REG_W-1:0] page_next;
  logic [REG_W-1:0] word_reg;
  logic [REG_W-1:0] word_next;

  // stepper only works out the next word, the flop stays here
  word_stepper word_stepper_i
  (
    .op(word_op),
    .cur(word_reg),
    .load_val(word_load_val),
    .next_val(word_next)
  );

  always_comb
  begin
    page_next = page_reg;
    if (page_load)
      page_next = page_load_val;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      page_reg <= REG_RESET;
      word_reg <= REG_RESET;
    end
    else
    begin
      page_reg <= page_next;
      word_reg <= word_next;
    end
  end

  // ==================================================
  // bank select
  logic bank_reg;
  logic bank_next;

  always_comb
  begin
    bank_next = bank_reg;
    // set wins if both arrive together
    if (bank_select_set_instr)
      bank_next = 1'b1;
    else if (bank_select_clear_instr)
      bank_next = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bank_reg <= BANK_RESET;
    else
      bank_reg <= bank_next;
  end

  // ==================================================
  // bank test results
  logic test_reg;
  logic test_next;
  logic test_valid_reg;
  logic test_valid_next;

  always_comb
  begin
    // inverted test reports the complement
    test_next = bank_select_test_inverted_instr ? ~bank_reg : bank_reg;
    test_valid_next = bank_select_test_instr |
                      bank_select_test_inverted_instr;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      test_reg <= 1'b0;
      test_valid_reg <= 1'b0;
    end
    else
    begin
      test_reg <= test_next;
      test_valid_reg <= test_valid_next;
    end
  end

  // ==================================================
  // port bit index
  logic [PORT_BIT_W-1:0] pbit_reg;
  logic [PORT_BIT_W-1:0] pbit_next;
  logic pbit_valid_reg;
  logic pbit_valid_next;

  always_comb
  begin
    // index taken before any step of the same cycle
    pbit_next = pbit_reg;
    if (port_bit_indirect_instr)
      pbit_next = PORT_BIT_W'(word_reg);
    pbit_valid_next = port_bit_indirect_instr;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pbit_reg <= PORT_BIT_W'(REG_RESET);
      pbit_valid_reg <= 1'b0;
    end
    else
    begin
      pbit_reg <= pbit_next;
      pbit_valid_reg <= pbit_valid_next;
    end
  end

  // ==================================================
  // outputs, all registered
  assign page_value = page_reg;
  assign word_value = word_reg;
  assign memory_bank_select = bank_reg;
  // address before any post-step, so the transfer uses the old word
  assign mem_addr = {bank_reg, page_reg, word_reg};
  assign bank_test_result = test_reg;
  assign bank_test_valid = test_valid_reg;
  assign port_bit_index = pbit_reg;
  assign port_bit_valid = pbit_valid_reg;

  // ==================================================
  // checks
  chk_bank_reset_zero: assert property (@(posedge clk)
    $rose(reset_n) |-> memory_bank_select == 1'b0)
    else $error("bank not zero after reset");
  chk_bank_set_one: assert property (@(posedge clk)
    disable iff (!reset_n)
    bank_select_set_instr |=> memory_bank_select)
    else $error("bank set failed");
  chk_bank_clear_zero: assert property (@(posedge clk)
    disable iff (!reset_n)
    bank_select_clear_instr && !bank_select_set_instr |=> !memory_bank_select)
    else $error("bank clear failed");
  chk_bank_holds_idle: assert property (@(posedge clk)
    disable iff (!reset_n)
    !bank_select_set_instr && !bank_select_clear_instr |=>
      $stable(memory_bank_select))
    else $error("bank changed without instruction");
  chk_bank_test_value: assert property (@(posedge clk)
    disable iff (!reset_n)
    bank_select_test_instr && !bank_select_test_inverted_instr |=>
      bank_test_valid && bank_test_result == $past(memory_bank_select))
    else $error("bank test wrong");
  chk_bank_test_inv: assert property (@(posedge clk)
    disable iff (!reset_n)
    bank_select_test_inverted_instr |=>
      bank_test_result == !$past(memory_bank_select))
    else $error("inverted bank test wrong");
  chk_test_valid_pulse: assert property (@(posedge clk)
    disable iff (!reset_n)
    !bank_select_test_instr && !bank_select_test_inverted_instr |=>
      !bank_test_valid)
    else $error("bank test valid without test");
  chk_word_post_inc: assert property (@(posedge clk)
    disable iff (!reset_n)
    word_op == WORD_INC |=> word_value == 4'($past(word_value) + 4'h1))
    else $error("word increment wrong");
  chk_word_post_dec: assert property (@(posedge clk)
    disable iff (!reset_n)
    word_op == WORD_DEC |=> word_value == 4'($past(word_value) - 4'h1))
    else $error("word decrement wrong");
  chk_word_load_value: assert property (@(posedge clk)
    disable iff (!reset_n)
    word_op == WORD_LOAD |=> word_value == $past(word_load_val))
    else $error("word load failed");
  chk_word_hold_idle: assert property (@(posedge clk)
    disable iff (!reset_n)
    word_op == WORD_HOLD |=> $stable(word_value))
    else $error("word changed while held");
  chk_addr_concat: assert property (@(posedge clk)
    disable iff (!reset_n)
    mem_addr[ADDR_W-1] == memory_bank_select &&
    mem_addr[ADDR_W-2:REG_W] == page_value &&
    mem_addr[REG_W-1:0] == word_value)
    else $error("address layout wrong");
  chk_port_bit_idx: assert property (@(posedge clk)
    disable iff (!reset_n)
    port_bit_indirect_instr |=> port_bit_valid &&
      port_bit_index == $past(word_value))
    else $error("port bit index wrong");
  chk_port_valid_pulse: assert property (@(posedge clk)
    disable iff (!reset_n)
    !port_bit_indirect_instr |=> !port_bit_valid && $stable(port_bit_index))
    else $error("port bit index moved without instruction");
  chk_page_load: assert property (@(posedge clk)
    disable iff (!reset_n)
    page_load |=> page_value == $past(page_load_val))
    else $error("page load failed");
  chk_page_hold_idle: assert property (@(posedge clk)
    disable iff (!reset_n)
    !page_load |=> $stable(page_value))
    else $error("page changed without load");

  cov_bank_set: cover property (@(posedge clk) bank_select_set_instr);
  cov_set_and_clear: cover property (@(posedge clk)
    bank_select_set_instr && bank_select_clear_instr);
  cov_inc_wrap: cover property (@(posedge clk)
    word_op == WORD_INC && word_value == 4'hF);
  cov_test_inv: cover property (@(posedge clk)
    bank_select_test_inverted_instr);
  cov_port_bit: cover property (@(posedge clk) port_bit_indirect_instr);
endmodule : data_memory_pointer_regs

// ### pkg/pointer_pkg.sv
// How it works
// - page and word registers are two 4-bit general data registers.
// - memory pages hold sixteen 4-bit words, spanned by the word register.
// - as a pointer the page register picks the page, the word the word.
// - two memory banks are chosen by a 1-bit bank select register.
// - reset forces bank select to zero, so bank 0 follows reset.
// - bank select changes only by its set and clear instructions and by reset.
// - two test instructions report bank select to the program.
// - the word register can post-step up or down after a transfer.
// - indirect port bit instructions use the word register as bit index.
package pointer_pkg;
  localparam int REG_W = 4;
  localparam int ADDR_W = 2 * REG_W + 1;
  localparam logic [REG_W-1:0] REG_RESET = 4'h0;
  localparam logic BANK_RESET = 1'b0;
  localparam logic [REG_W-1:0] WORD_STEP = 4'h1;
  localparam int PORT_BIT_W = 4;

  // word register operation requested by the decoder
  typedef enum logic [1:0]
  {
    WORD_HOLD = 2'b00,
    WORD_LOAD = 2'b01,
    WORD_INC = 2'b10,
    WORD_DEC = 2'b11
  } word_op_e;
endpackage : pointer_pkg

// ### rtl/word_stepper.sv
`timescale 1ns/10ps
module word_stepper
(
  // operation
  input wire pointer_pkg::word_op_e op,
  input wire logic [pointer_pkg::REG_W-1:0] cur,
  input wire logic [pointer_pkg::REG_W-1:0] load_val,
  // result
  output logic [pointer_pkg::REG_W-1:0] next_val
);
  import pointer_pkg::*;

  always_comb
  begin
    unique case (op)
      WORD_HOLD: next_val = cur;
      WORD_LOAD: next_val = load_val;
      // wraps inside the page: no carry into the page register
      WORD_INC: next_val = cur + WORD_STEP;
      WORD_DEC: next_val = cur - WORD_STEP;
    endcase
  end
endmodule : word_stepper

// ### verification/data_ram_model.sv
`timescale 1ns/10ps
module data_ram_model
(
  // memory side
  input wire logic clk,
  input wire logic [pointer_pkg::ADDR_W-1:0] addr,
  input wire logic wr_en,
  input wire logic [pointer_pkg::REG_W-1:0] wr_data,
  output logic [pointer_pkg::REG_W-1:0] rd_data
);
  import pointer_pkg::*;
  logic [REG_W-1:0] mem [0:(1<<ADDR_W)-1];
  // write uses the address before a same-edge word step
  always @(posedge clk)
    if (wr_en)
      mem[addr] <= wr_data;
  assign rd_data = mem[addr];
endmodule : data_ram_model

// ### verification/data_memory_pointer_regs_test.sv
`timescale 1ns/10ps
module data_memory_pointer_regs_test;
  import pointer_pkg::*;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
  logic clk = 1'b0, reset_n = 1'b0, page_load = 1'b0;
  logic set_i = 1'b0, clr_i = 1'b0, test_i = 1'b0, inv_test = 1'b0;
  logic port_i = 1'b0, wr_en = 1'b0;
  logic [REG_W-1:0] page_val = 4'h0, word_val = 4'h0, wr_data = 4'h0;
  logic [REG_W-1:0] rd_data;
  word_op_e word_op = WORD_HOLD;
  logic [REG_W-1:0] page_o, word_o;
  logic [PORT_BIT_W-1:0] bit_idx;
  logic bank, t_res, t_val, p_val;
  logic [ADDR_W-1:0] addr;
  int failures = 0, checks = 0;
  always #5 clk = ~clk;
  data_memory_pointer_regs data_memory_pointer_regs_i (.clk(clk),
    .reset_n(reset_n), .page_load(page_load), .page_load_val(page_val),
    .word_op(word_op), .word_load_val(word_val),
    .bank_select_set_instr(set_i), .bank_select_clear_instr(clr_i),
    .bank_select_test_instr(test_i),
    .bank_select_test_inverted_instr(inv_test),
    .port_bit_indirect_instr(port_i), .page_value(page_o),
    .word_value(word_o), .memory_bank_select(bank), .mem_addr(addr),
    .bank_test_result(t_res), .bank_test_valid(t_val),
    .port_bit_index(bit_idx), .port_bit_valid(p_val));
  data_ram_model data_ram_model_i (.clk(clk), .addr(addr), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data));
  // ==========
  // drivers
  task automatic tick();
    @(posedge clk);
    {page_load, set_i, clr_i, test_i, inv_test, port_i, wr_en} <= 7'h00;
    word_op <= WORD_HOLD;
    #1;
  endtask : tick
  task automatic load(input logic [3:0] p, input logic [3:0] w);
    @(posedge clk);
    page_load <= 1'b1;
    page_val <= p;
    word_op <= WORD_LOAD;
    word_val <= w;
    tick();
  endtask : load
  // ==========
  // scenarios
  task automatic t_pointer();
    `CHK(addr, 9'h000)
    load(4'hA, 4'h3);
    `CHK({page_o, word_o}, 8'hA3)
    `CHK(addr, 9'h0A3)
  endtask : t_pointer
  task automatic t_store_inc();
    load(4'hA, 4'hF);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_data <= 4'h9;
    word_op <= WORD_INC;
    tick();
    `CHK(addr, 9'h0A0)
    @(posedge clk);
    word_op <= WORD_DEC;
    tick();
    `CHK(rd_data, 4'h9)
  endtask : t_store_inc
  task automatic t_bank();
    @(posedge clk);
    set_i <= 1'b1;
    tick();
    `CHK(addr, 9'h1AF)
    @(posedge clk);
    inv_test <= 1'b1;
    tick();
    `CHK({t_val, t_res}, 2'h2)
    @(posedge clk);
    test_i <= 1'b1;
    tick();
    `CHK({t_val, t_res}, 2'h3)
    tick();
    `CHK(t_val, 1'b0)
    @(posedge clk);
    clr_i <= 1'b1;
    tick();
    @(posedge clk);
    test_i <= 1'b1;
    tick();
    `CHK({t_val, t_res, bank}, 3'h4)
    @(posedge clk);
    inv_test <= 1'b1;
    tick();
    `CHK({t_val, t_res, bank}, 3'h6)
    @(posedge clk);
    set_i <= 1'b1;
    clr_i <= 1'b1;
    tick();
    `CHK(bank, 1'b1)
  endtask : t_bank
  task automatic t_port();
    load(4'h0, 4'h7);
    @(posedge clk);
    port_i <= 1'b1;
    tick();
    `CHK({p_val, bit_idx}, 5'h17)
    tick();
    `CHK({p_val, bit_idx}, 5'h07)
  endtask : t_port
  task automatic t_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    tick();
    `CHK({bank, addr}, 10'h000)
    @(posedge clk);
    reset_n <= 1'b1;
    tick();
    `CHK({bank, t_val, p_val}, 3'h0)
  endtask : t_reset
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    tick();
    t_pointer();
    t_store_inc();
    t_bank();
    t_port();
    t_reset();
    give_verdict();
  end
  initial
  begin
    #2000;
    failures++;
    give_verdict();
  end
endmodule : data_memory_pointer_regs_test
